/* inc/bir_pkg.sv */
`default_nettype none
package bir_pkg;
    // clock and timer tick
    localparam int CLK_PERIOD_NS = 8;
    localparam int TIMER_TICK_NS = 1000;
    localparam int TIMER_TICK_CYC = (TIMER_TICK_NS + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;

    // register bus
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFS_MP_STATUS = 8'h00;
    localparam logic [7:0] OFS_MP_MASK = 8'h04;
    localparam logic [7:0] OFS_MP_CPU_DEST = 8'h08;
    localparam logic [7:0] OFS_MP_IPI = 8'h0c;
    localparam logic [7:0] OFS_EDGE_LEVEL = 8'h10;
    localparam logic [7:0] OFS_ROUTE = 8'h14;
    localparam logic [7:0] OFS_LEG_PEND = 8'h18;
    localparam logic [7:0] OFS_LEG_MASK = 8'h1c;
    localparam logic [7:0] OFS_TIMER0 = 8'h20;
    localparam logic [7:0] OFS_TIMER1 = 8'h24;
    localparam logic [7:0] OFS_TIMER2 = 8'h28;
    localparam logic [7:0] OFS_TIMER3 = 8'h2c;

    // multiprocessor controller sources
    localparam int NUM_CPU = 2;
    localparam int MP_EXT = 16;
    localparam int MP_SRC = 22;
    localparam int SRC_IPI0 = 16;
    localparam int SRC_TMR0 = 18;
    localparam int NUM_TMR = 4;
    localparam int TMR_W = 16;
    localparam int IN_LEGACY = 0;
    localparam int IN_MEM_ERR = 1;
    localparam int IN_ETH = 2;
    localparam int IN_VME0 = 5;
    localparam int IN_SLOT0 = 9;
    localparam int IN_LM0 = 13;
    // sticky sources: edge input 1, the two ipis and four timers
    localparam logic [21:0] MP_STICKY = 22'h3f0002;
    // inputs 3, 4 and 15 are unused and stay inactive
    localparam logic [15:0] MP_UNUSED = 16'h8018;
    localparam logic [21:0] MP_MASK_RST = 22'h000000;
    localparam logic [21:0] MP_DEST_RST = 22'h000000;

    // legacy controller
    localparam int LEG_W = 16;
    localparam int LEG_CASCADE = 2;
    localparam int LEG_LM_LINE = 5;
    localparam logic [15:0] LEG_FIXED = 16'h2107;
    localparam logic [15:0] ELC_RST = 16'h0000;
    localparam logic [15:0] LEG_MASK_RST = 16'hffff;
    localparam int NUM_PCI = 4;
    localparam int ROUTE_OFF_BIT = 7;
    localparam logic [31:0] ROUTE_RST = 32'h80808080;

    // synchronised pins
    localparam int SYN_MEM = 0;
    localparam int SYN_ETH = 1;
    localparam int SYN_LINT = 2;
    localparam int SYN_SLOT1 = 6;
    localparam int SYN_SLOT2 = 10;
    localparam int SYN_EXP = 14;
    localparam int SYN_LM = 18;
    localparam int SYN_ISA = 20;
    localparam int SYN_W = 36;
    localparam logic [35:0] SYN_IDLE = 36'h00000fffff;
endpackage : bir_pkg
`default_nettype wire

/* rtl/bir_board_int_routing.sv */
// Operation
// - deliver to at most two processors, accept sixteen external inputs
// - add two interprocessor and four timer sources internally
// - legacy requests pass the bridge; its output is input 0, high level
// - input 1 is a falling-edge memory error request
// - inputs 5 to 8 are low level requests from bridge outputs 0 to 3
// - inputs 9 to 12 are shared slot lines, slot two rotated by one
// - ethernet, bridge output 0, slots, monitors also reach legacy side
// - legacy side has fifteen request lines as two cascaded controllers
// - each line edge or level, except fixed lines 0, 1, 2, 8, 13
// - four pci lines, each steerable to one of eleven legacy lines
// - several pci lines may share one legacy line
// - every legacy line resets to edge mode
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module bir_board_int_routing #(
    parameter int TICK_DIV = bir_pkg::TIMER_TICK_CYC
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [bir_pkg::ADDR_W-1:0] addr,
    input wire logic [bir_pkg::DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [bir_pkg::DATA_W-1:0] rdata,
    input wire logic mem_err_n,
    input wire logic eth_int_n,
    input wire logic [3:0] bridge_local_int_out_n,
    input wire logic [3:0] mezzanine_slot_one_int_n,
    input wire logic [3:0] mezzanine_slot_two_int_n,
    input wire logic [3:0] expansion_slot_int_n,
    input wire logic [1:0] location_monitor_signal_n,
    input wire logic [15:0] isa_irq,
    output logic [bir_pkg::NUM_CPU-1:0] cpu_int,
    output logic int_out,
    output logic legacy_int_out
);
    import bir_pkg::*;

    typedef struct packed {
        logic [SYN_W-1:0] sync1;
        logic [SYN_W-1:0] sync2;
        logic [SYN_W-1:0] sync3;
        logic [SYN_W-1:0] filt;
        logic mem_prev;
        logic [LEG_W-1:0] leg_prev;
        logic [MP_SRC-1:0] mp_stat;
        logic [MP_SRC-1:0] mp_mask;
        logic [MP_SRC-1:0] mp_dest;
        logic [LEG_W-1:0] elc;
        logic [31:0] route;
        logic [LEG_W-1:0] leg_pend;
        logic [LEG_W-1:0] leg_mask;
        logic [NUM_TMR*TMR_W-1:0] reload;
        logic [NUM_TMR*TMR_W-1:0] tcount;
        logic [15:0] presc;
        logic [DATA_W-1:0] rdata;
        logic [NUM_CPU-1:0] cpu_int;
        logic int_out;
        logic legacy_out;
    } bir_state_t;

    localparam bir_state_t BIR_RST = '{
        sync1: SYN_IDLE,
        sync2: SYN_IDLE,
        sync3: SYN_IDLE,
        filt: SYN_IDLE,
        mem_prev: 1'b0,
        leg_prev: '0,
        mp_stat: '0,
        mp_mask: MP_MASK_RST,
        mp_dest: MP_DEST_RST,
        elc: ELC_RST,
        route: ROUTE_RST,
        leg_pend: '0,
        leg_mask: LEG_MASK_RST,
        reload: '0,
        tcount: '0,
        presc: '0,
        rdata: '0,
        cpu_int: '0,
        int_out: 1'b0,
        legacy_out: 1'b0
    };

    localparam logic [15:0] TICK_LAST = 16'(TICK_DIV - 1);

    bir_state_t s_reg;
    bir_state_t s_next;

    logic [SYN_W-1:0] pins;
    assign pins = {isa_irq, location_monitor_signal_n, expansion_slot_int_n,
                   mezzanine_slot_two_int_n, mezzanine_slot_one_int_n,
                   bridge_local_int_out_n, eth_int_n, mem_err_n};

    always_comb begin
        logic [NUM_PCI-1:0] pci_act;
        logic [LEG_W-1:0] steered;
        logic [LEG_W-1:0] raw;
        logic [LEG_W-1:0] rise;
        logic [LEG_W-1:0] leg_clr;
        logic [LEG_W-1:0] leg_act;
        logic [MP_EXT-1:0] mp_in;
        logic [MP_SRC-1:0] mp_set;
        logic [MP_SRC-1:0] mp_clr;
        logic [MP_SRC-1:0] mp_live;
        logic [MP_SRC-1:0] mp_act;
        logic [3:0] line;
        logic tick;
        logic [TMR_W-1:0] cnt;
        logic [TMR_W-1:0] rld;
        logic [DATA_W-1:0] rd_val;
        pci_act = '0;
        steered = '0;
        raw = '0;
        rise = '0;
        leg_clr = '0;
        leg_act = '0;
        mp_in = '0;
        mp_set = '0;
        mp_clr = '0;
        mp_live = '0;
        mp_act = '0;
        line = '0;
        tick = 1'b0;
        cnt = '0;
        rld = '0;
        rd_val = '0;
        s_next = s_reg;

        // three-stage synchroniser; a change counts once stages 2 and 3 agree
        s_next.sync1 = pins;
        s_next.sync2 = s_reg.sync1;
        s_next.sync3 = s_reg.sync2;
        for (int i = 0; i < SYN_W; i++) begin
            if (s_reg.sync2[i] == s_reg.sync3[i]) begin
                s_next.filt[i] = s_reg.sync3[i];
            end
        end

        // pci lines seen by the bridge: ethernet, vme output 0, none, slots
        pci_act[0] = ~s_reg.filt[SYN_ETH];
        pci_act[1] = ~s_reg.filt[SYN_LINT];
        pci_act[2] = 1'b0;
        pci_act[3] = ~(&s_reg.filt[SYN_SLOT1 +: 4])
                   | ~(&s_reg.filt[SYN_SLOT2 +: 4])
                   | ~(&s_reg.filt[SYN_EXP +: 4]);

        // steering: an or per target line lets several pci lines share it
        for (int p = 0; p < NUM_PCI; p++) begin
            line = s_reg.route[p*8 +: 4];
            if (!s_reg.route[p*8 + ROUTE_OFF_BIT]
                    && !LEG_FIXED[line]) begin
                steered[line] = steered[line] | pci_act[p];
            end
        end

        // legacy request lines; the cascade line carries no pin of its own
        raw = s_reg.filt[SYN_ISA +: LEG_W] | steered;
        raw[LEG_LM_LINE] = raw[LEG_LM_LINE]
                         | ~(&s_reg.filt[SYN_LM +: 2]);
        raw[LEG_CASCADE] = 1'b0;
        s_next.leg_prev = raw;
        rise = raw & ~s_reg.leg_prev;

        if (wr_en && addr == OFS_LEG_PEND) begin
            leg_clr = wdata[LEG_W-1:0];
        end
        // edge lines latch and clear by writing one; the set wins
        for (int i = 0; i < LEG_W; i++) begin
            if (s_reg.elc[i]) begin
                s_next.leg_pend[i] = raw[i];
            end else begin
                s_next.leg_pend[i] = (s_reg.leg_pend[i] & ~leg_clr[i])
                                   | rise[i];
            end
        end
        s_next.leg_pend[LEG_CASCADE] = 1'b0;

        // slave group reaches the master through the cascade line
        leg_act = s_reg.leg_pend & ~s_reg.leg_mask;
        leg_act[LEG_CASCADE] = |leg_act[15:8];
        s_next.legacy_out = |leg_act[7:0];

        // external inputs of the multiprocessor controller, active high
        mp_in[IN_LEGACY] = s_reg.legacy_out;
        mp_in[IN_MEM_ERR] = ~s_reg.filt[SYN_MEM];
        mp_in[IN_ETH] = ~s_reg.filt[SYN_ETH];
        for (int k = 0; k < 4; k++) begin
            mp_in[IN_VME0 + k] = ~s_reg.filt[SYN_LINT + k];
            mp_in[IN_SLOT0 + k] = ~s_reg.filt[SYN_SLOT1 + k]
                                | ~s_reg.filt[SYN_SLOT2 + ((k + 3) % 4)]
                                | ~s_reg.filt[SYN_EXP + k];
        end
        mp_in[IN_LM0] = ~s_reg.filt[SYN_LM];
        mp_in[IN_LM0 + 1] = ~s_reg.filt[SYN_LM + 1];
        mp_in = mp_in & ~MP_UNUSED;

        // memory error is taken on its falling pin edge
        s_next.mem_prev = mp_in[IN_MEM_ERR];
        mp_set[IN_MEM_ERR] = mp_in[IN_MEM_ERR] & ~s_reg.mem_prev;
        mp_live[MP_EXT-1:0] = mp_in;

        // interprocessor requests are raised by a write of ones
        if (wr_en && addr == OFS_MP_IPI) begin
            mp_set[SRC_IPI0 +: 2] = wdata[1:0];
        end

        // timers count down on the tick; reload of zero stops a timer
        tick = (s_reg.presc == TICK_LAST);
        s_next.presc = tick ? '0 : s_reg.presc + 16'h0001;
        for (int t = 0; t < NUM_TMR; t++) begin
            cnt = s_reg.tcount[t*TMR_W +: TMR_W];
            rld = s_reg.reload[t*TMR_W +: TMR_W];
            if (rld == '0) begin
                s_next.tcount[t*TMR_W +: TMR_W] = '0;
            end else if (tick) begin
                if (cnt <= 16'h0001) begin
                    s_next.tcount[t*TMR_W +: TMR_W] = rld;
                    mp_set[SRC_TMR0 + t] = (cnt == 16'h0001);
                end else begin
                    s_next.tcount[t*TMR_W +: TMR_W] = cnt - 16'h0001;
                end
            end
        end

        // sticky bits clear by writing one, the set wins; level bits follow
        if (wr_en && addr == OFS_MP_STATUS) begin
            mp_clr = wdata[MP_SRC-1:0];
        end
        s_next.mp_stat = (MP_STICKY & ((s_reg.mp_stat & ~mp_clr) | mp_set))
                       | (~MP_STICKY & mp_live);

        // delivery: each source goes to the processor picked by its dest bit
        mp_act = s_reg.mp_stat & s_reg.mp_mask;
        s_next.cpu_int[0] = |(mp_act & ~s_reg.mp_dest);
        s_next.cpu_int[1] = |(mp_act & s_reg.mp_dest);
        s_next.int_out = |mp_act;

        // register writes
        if (wr_en) begin
            unique case (addr)
                OFS_MP_MASK: begin
                    s_next.mp_mask = wdata[MP_SRC-1:0];
                end
                OFS_MP_CPU_DEST: begin
                    s_next.mp_dest = wdata[MP_SRC-1:0];
                end
                OFS_EDGE_LEVEL: begin
                    s_next.elc = wdata[LEG_W-1:0] & ~LEG_FIXED;
                end
                OFS_ROUTE: begin
                    s_next.route = wdata;
                end
                OFS_LEG_MASK: begin
                    s_next.leg_mask = wdata[LEG_W-1:0];
                end
                OFS_TIMER0: begin
                    s_next.reload[0*TMR_W +: TMR_W] = wdata[15:0];
                end
                OFS_TIMER1: begin
                    s_next.reload[1*TMR_W +: TMR_W] = wdata[15:0];
                end
                OFS_TIMER2: begin
                    s_next.reload[2*TMR_W +: TMR_W] = wdata[15:0];
                end
                OFS_TIMER3: begin
                    s_next.reload[3*TMR_W +: TMR_W] = wdata[15:0];
                end
                OFS_MP_STATUS, OFS_MP_IPI, OFS_LEG_PEND: begin
                    // one-shot strobes, already decoded above
                end
                default: begin
                end
            endcase
        end

        // register reads, data in the following cycle only
        if (rd_en) begin
            unique case (addr)
                OFS_MP_STATUS: begin
                    rd_val = {10'h000, s_reg.mp_stat};
                end
                OFS_MP_MASK: begin
                    rd_val = {10'h000, s_reg.mp_mask};
                end
                OFS_MP_CPU_DEST: begin
                    rd_val = {10'h000, s_reg.mp_dest};
                end
                OFS_MP_IPI: begin
                    // write-only strobe, nothing to show
                    rd_val = '0;
                end
                OFS_EDGE_LEVEL: begin
                    rd_val = {16'h0000, s_reg.elc};
                end
                OFS_ROUTE: begin
                    rd_val = s_reg.route;
                end
                OFS_LEG_PEND: begin
                    rd_val = {16'h0000, s_reg.leg_pend};
                end
                OFS_LEG_MASK: begin
                    rd_val = {16'h0000, s_reg.leg_mask};
                end
                OFS_TIMER0: begin
                    rd_val = {16'h0000, s_reg.tcount[15:0]};
                end
                OFS_TIMER1: begin
                    rd_val = {16'h0000, s_reg.tcount[31:16]};
                end
                OFS_TIMER2: begin
                    rd_val = {16'h0000, s_reg.tcount[47:32]};
                end
                OFS_TIMER3: begin
                    rd_val = {16'h0000, s_reg.tcount[63:48]};
                end
                default: begin
                    rd_val = '0;
                end
            endcase
        end
        s_next.rdata = rd_val;
    end

    // reset leaves every legacy line in edge mode
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            s_reg <= BIR_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rdata = s_reg.rdata;
    assign cpu_int = s_reg.cpu_int;
    assign int_out = s_reg.int_out;
    assign legacy_int_out = s_reg.legacy_out;
endmodule : bir_board_int_routing
`default_nettype wire

/* verif/bir_src_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bir_src_model (
    input wire logic [19:0] req,
    output logic mem_err_n,
    output logic eth_int_n,
    output logic [3:0] lint_n,
    output logic [3:0] s1_n,
    output logic [3:0] s2_n,
    output logic [3:0] sx_n,
    output logic [1:0] lm_n
);
    // active-low sources: a released line is driven high, inactive
    assign eth_int_n = !req[0];
    assign lint_n = ~req[4:1];
    assign s1_n = ~req[8:5];
    assign s2_n = ~req[12:9];
    assign sx_n = ~req[16:13];
    assign lm_n = ~req[18:17];
    assign mem_err_n = !req[19];
endmodule : bir_src_model
`default_nettype wire

/* verif/bir_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module bir_chk (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [bir_pkg::ADDR_W-1:0] addr,
    input wire logic [bir_pkg::DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic mem_err_n,
    input wire logic [3:0] bridge_local_int_out_n,
    input wire logic [3:0] mezzanine_slot_two_int_n,
    input wire logic [1:0] location_monitor_signal_n,
    input wire logic [bir_pkg::NUM_CPU-1:0] cpu_int,
    input wire logic int_out,
    input wire logic legacy_int_out
);
    import bir_pkg::*;
    logic [21:0] msk_reg;
    logic [21:0] dst_reg;
    logic [15:0] lmsk_reg;
    // shadow the mask writes so outputs can be judged without a read
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            msk_reg <= MP_MASK_RST;
            dst_reg <= MP_DEST_RST;
            lmsk_reg <= LEG_MASK_RST;
        end else if (wr_en) begin
            if (addr == OFS_MP_MASK) msk_reg <= wdata[21:0];
            if (addr == OFS_MP_CPU_DEST) dst_reg <= wdata[21:0];
            if (addr == OFS_LEG_MASK) lmsk_reg <= wdata[15:0];
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);
    cpu_summary_a: assert property (int_out == (|cpu_int))
        else $error("int_out disagrees with cpu_int");
    legacy_path_a: assert property (
        (legacy_int_out && msk_reg[0] && !dst_reg[0])[*4] |-> cpu_int[0])
        else $error("legacy output not delivered");
    mem_edge_a: assert property ($fell(mem_err_n) ##1
        (!mem_err_n && msk_reg[1] && !dst_reg[1])[*4] |-> ##[0:4] cpu_int[0])
        else $error("memory error edge not delivered");
    vme_order_a: assert property ((!bridge_local_int_out_n[3]
        && msk_reg[8] && $stable(dst_reg))[*8] |-> cpu_int[dst_reg[8]])
        else $error("bridge output 3 not on input 8");
    slot_share_a: assert property ((!mezzanine_slot_two_int_n[3]
        && msk_reg[9] && $stable(dst_reg))[*8] |-> cpu_int[dst_reg[9]])
        else $error("slot two line D not on input 9");
    unused_quiet_a: assert property (
        (msk_reg & ~{6'h00, MP_UNUSED}) == 22'h000000 |=> !int_out)
        else $error("request from masked or unused input");
    legacy_masked_a: assert property (
        lmsk_reg == 16'hffff ##1 lmsk_reg == 16'hffff |-> !legacy_int_out)
        else $error("legacy output while all lines masked");
    lm_legacy_a: assert property ((
        !location_monitor_signal_n[0] && !lmsk_reg[5])[*8] |-> legacy_int_out)
        else $error("monitor not seen by legacy side");
endmodule : bir_chk
bind bir_board_int_routing bir_chk bir_chk_i (.ref_clk, .resetn, .addr,
    .wdata, .wr_en, .mem_err_n, .bridge_local_int_out_n,
    .mezzanine_slot_two_int_n, .location_monitor_signal_n, .cpu_int,
    .int_out, .legacy_int_out);
`default_nettype wire

/* verif/bir_board_int_routing_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module bir_board_int_routing_tb;
    import bir_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [19:0] req = 20'h0;
    logic [15:0] isa_irq = 16'h0000;
    logic [31:0] rdata;
    logic [1:0] cpu_int, lm_n;
    logic int_out, legacy_int_out, mem_err_n, eth_int_n;
    logic [3:0] lint_n, s1_n, s2_n, sx_n;
    int bad_count = 0;
    int checks_done = 0;
    int i;
    bir_src_model bir_src_model_i (.req(req), .mem_err_n(mem_err_n),
        .eth_int_n(eth_int_n), .lint_n(lint_n), .s1_n(s1_n), .s2_n(s2_n),
        .sx_n(sx_n), .lm_n(lm_n));
    // short timer tick keeps the timer periods to a few cycles
    bir_board_int_routing #(.TICK_DIV(4)) bir_board_int_routing_i (
        .ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
        .mem_err_n(mem_err_n), .eth_int_n(eth_int_n),
        .bridge_local_int_out_n(lint_n), .mezzanine_slot_one_int_n(s1_n),
        .mezzanine_slot_two_int_n(s2_n), .expansion_slot_int_n(sx_n),
        .location_monitor_signal_n(lm_n), .isa_irq(isa_irq),
        .cpu_int(cpu_int), .int_out(int_out),
        .legacy_int_out(legacy_int_out));
    initial forever #4 ref_clk = ~ref_clk;
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        @(negedge ref_clk);
        chk($sformatf("reg %h", a), e, rdata);
    endtask : rd
    // the pin filter needs several cycles, so a change is given eight, except two that are given none
    task automatic src(input int b, input logic v, input int n);
        @(posedge ref_clk);
        req[b] <= v;
        repeat (n) @(posedge ref_clk);
    endtask : src
    function automatic int mp_bit(input int b);
        if (b == 0) return 2;
        if (b < 5) return 4 + b;
        if (b < 9) return 4 + b;
        if (b < 13) return 9 + (b - 8) % 4;
        if (b < 17) return b - 4;
        return b - 4;
    endfunction : mp_bit
    task automatic test_done();
        if (bad_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        rd(OFS_MP_MASK, 32'h0);
        rd(OFS_EDGE_LEVEL, 32'h0);
        rd(OFS_ROUTE, 32'h80808080);
        rd(OFS_LEG_MASK, 32'hffff);
        rd(8'h40, 32'h0);
        wr(OFS_EDGE_LEVEL, 32'hffff);
        rd(OFS_EDGE_LEVEL, 32'hdef8);
        wr(OFS_MP_MASK, 32'h3fffff);
        rd(OFS_MP_STATUS, 32'h0);
        for (i = 0; i < 19; i++) begin
            src(i, 1'b1, 8);
            rd(OFS_MP_STATUS, 32'h1 << mp_bit(i));
            src(i, 1'b0, 8);
        end
        src(5, 1'b1, 0);
        src(13, 1'b1, 8);
        src(5, 1'b0, 8);
        rd(OFS_MP_STATUS, 32'h200);
        src(13, 1'b0, 8);
        src(19, 1'b1, 8);
        rd(OFS_MP_STATUS, 32'h2);
        wr(OFS_MP_STATUS, 32'h2);
        src(19, 1'b0, 8);
        rd(OFS_MP_STATUS, 32'h0);
        wr(OFS_MP_CPU_DEST, 32'h20000);
        wr(OFS_MP_IPI, 32'h3);
        rd(OFS_MP_STATUS, 32'h30000);
        chk("cpu_int", 32'h3, {30'h0, cpu_int});
        wr(OFS_MP_CPU_DEST, 32'h0);
        for (i = 0; i < 4; i++) begin
            wr(OFS_TIMER0 + 8'(4 * i), 32'h2);
        end
        repeat (12) @(posedge ref_clk);
        for (i = 0; i < 4; i++) begin
            wr(OFS_TIMER0 + 8'(4 * i), 32'h0);
        end
        rd(OFS_MP_STATUS, 32'h3f0000);
        wr(OFS_MP_STATUS, 32'h3f0000);
        wr(OFS_LEG_PEND, 32'hffff);
        wr(OFS_ROUTE, 32'h80800a0a);
        wr(OFS_EDGE_LEVEL, 32'h400);
        wr(OFS_LEG_MASK, 32'hfbdb);
        // only the legacy input stays enabled while it handles pci lines
        wr(OFS_MP_MASK, 32'h1);
        src(0, 1'b1, 8);
        rd(OFS_LEG_PEND, 32'h400);
        rd(OFS_MP_STATUS, 32'h5);
        src(0, 1'b0, 0);
        src(1, 1'b1, 8);
        rd(OFS_LEG_PEND, 32'h400);
        src(1, 1'b0, 8);
        rd(OFS_LEG_PEND, 32'h0);
        chk("legacy_int_out", 32'h0, {31'h0, legacy_int_out});
        wr(OFS_ROUTE, 32'h80808008);
        src(0, 1'b1, 8);
        rd(OFS_LEG_PEND, 32'h0);
        src(0, 1'b0, 8);
        src(17, 1'b1, 8);
        rd(OFS_LEG_PEND, 32'h20);
        chk("legacy_int_out", 32'h1, {31'h0, legacy_int_out});
        src(17, 1'b0, 8);
        wr(OFS_LEG_PEND, 32'h20);
        // an isa pin on the slave group reaches input 0 via the cascade
        @(posedge ref_clk);
        isa_irq <= 16'h1000;
        repeat (8) @(posedge ref_clk);
        rd(OFS_LEG_PEND, 32'h1000);
        chk("legacy_int_out", 32'h0, {31'h0, legacy_int_out});
        wr(OFS_LEG_MASK, 32'hebdb);
        rd(OFS_LEG_PEND, 32'h1000);
        rd(OFS_MP_STATUS, 32'h1);
        chk("cpu_int", 32'h1, {30'h0, cpu_int});
        chk("int_out", 32'h1, {31'h0, int_out});
        chk("legacy_int_out", 32'h1, {31'h0, legacy_int_out});
        // a second reset must bring every line back to edge mode
        @(posedge ref_clk);
        isa_irq <= 16'h0000;
        resetn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        rd(OFS_EDGE_LEVEL, 32'h0);
        rd(OFS_LEG_PEND, 32'h0);
        chk("cpu_int", 32'h0, {30'h0, cpu_int});
        test_done();
    end
    // whole sequence is under seven hundred cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        test_done();
    end
endmodule : bir_board_int_routing_tb
`default_nettype wire
